/* core/loader_pkg.sv */
package loader_pkg;

  // Word and channel layout
  localparam int unsigned DATA_W      = 10;
  localparam int unsigned NUM_CH      = 6;
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned SYNC_STAGES = 2;

  // Channel address codes
  localparam logic [2:0] ADDR_FIRST_CH = 3'h0;
  localparam logic [2:0] ADDR_LAST_CH  = 3'h5;
  localparam logic [2:0] ADDR_SEQ      = 3'h7;

  // Reset values
  localparam logic [9:0] WORD_RST = 10'h000;

  // Upstream word rate limit and derived spacing at the core clock
  localparam int unsigned MAX_WORD_RATE_MSPS = 75;
  localparam int unsigned CLK_MHZ            = 200;
  localparam int unsigned MIN_WORD_CYCLES    =
    (CLK_MHZ + MAX_WORD_RATE_MSPS - 1) / MAX_WORD_RATE_MSPS;

  // Output buffer depth
  localparam int unsigned BUF_DEPTH = 2;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_e;

endpackage : loader_pkg

/* core/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;

  always_comb begin
    next_meta   = meta;
    next_stable = stable;
    if (ce_i) begin
      next_meta   = pin_i;
      next_stable = meta;
    end
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= '0;
      stable <= '0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
    end
  end

  assign sync_o = stable;

endmodule : pin_sync

/* core/two_entry_buffer.sv */
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH != 2) begin : g_bad_depth
      $error("two_entry_buffer supports DEPTH of 2 only");
    end
  endgenerate

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0]   next_count;
  logic          push;
  logic          pop;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    push        = ce_i && in_valid_i && in_ready_o;
    pop         = ce_i && out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; valid gates it
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule : two_entry_buffer

/* core/six_channel_decimating_input_loader.sv */
// How it works
// [R1] Pixel port is ten bits; bit nine is the most significant.
// [R2] Each captured word is steered into one of six channel latches.
// [R3] Edge select low captures on falling pixel clock, high on rising.
// [R4] Controller keeps words at or below 75 million per second.
// [R5] Two selection modes: direct addressing, or internal sequencing.
// [R6] Three address lines pick the channel latch in addressed loading.
// [R7] Addresses 0 to 5 load channels 0 to 5 while selected.
// [R8] Shared input starts sequencing at address 7, else chip select.
// [R9] Address 7, direction low: sequence runs channel 0 up to 5.
// [R10] Direction input picks the starting channel of the sequence.
// [R11] Transfer high at rising edge moves words at the next falling edge.
// [R12] Polarity high puts outputs above midpoint, low below it.
// [R13] Standby idles capture, sequencing and transfer, while the frame buffer still drains; release resumes at once.
// [R14] At address 7 a pulse on the shared input starts sequencing.
// [R15] Counter runs 0 to 5 with direction low, 5 to 0 high.
// [R16] Transfer updates all six converter words together.
// [R17] Addressed capture without chip select changes no latch.
`timescale 1ns/1ps
module six_channel_decimating_input_loader #(
  parameter int unsigned DATA_W = loader_pkg::DATA_W,
  parameter int unsigned NUM_CH = loader_pkg::NUM_CH
) (
  // Clock, reset, enable
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // Panel-side pins
  input  wire logic                     pixel_clk_i,
  input  wire logic [DATA_W-1:0]        pixel_word_in_i,
  input  wire logic                     capture_edge_select_i,
  input  wire logic                     sequence_direction_i,
  input  wire logic [2:0]               channel_address_i,
  input  wire logic                     seq_start_or_select_i,
  input  wire logic                     converter_transfer_strobe_i,
  input  wire logic                     output_polarity_select_i,
  input  wire logic                     standby_request_i,
  // Converter side
  output logic      [NUM_CH*DATA_W-1:0] column_outputs_o,
  output logic                          column_above_mid_o,
  output logic                          column_valid_o,
  input  wire logic                     column_ready_i,
  // Status
  output logic                          transfer_ready_o,
  output logic                          transfer_lost_o,
  output logic                          rate_violation_o,
  output logic                          sequence_busy_o,
  output logic                          standby_o
);

  localparam int unsigned PIN_W  = DATA_W + 10;
  localparam int unsigned FRAME_W = NUM_CH * DATA_W + 1;
  localparam int unsigned GAP_W  = $clog2(loader_pkg::MIN_WORD_CYCLES + 1);

  generate
    if (DATA_W != loader_pkg::DATA_W || NUM_CH != loader_pkg::NUM_CH) begin : g_bad_cfg
      $error("loader serves ten-bit words and six channels only");
    end
  endgenerate

  // Pin synchronisers, one vector so all pins share the same delay
  logic [PIN_W-1:0]  pins_raw;
  logic [PIN_W-1:0]  pins_sync;
  logic [DATA_W-1:0] s_word;
  logic              s_pclk;
  logic              s_edge_sel;
  logic              s_dir;
  logic [2:0]        s_addr;
  logic              s_start_cs;
  logic              s_xfr;
  logic              s_pol;
  logic              s_standby_request;

  assign pins_raw = {pixel_word_in_i, pixel_clk_i, capture_edge_select_i,
                     sequence_direction_i, channel_address_i,
                     seq_start_or_select_i, converter_transfer_strobe_i,
                     output_polarity_select_i, standby_request_i};

  pin_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pin_i  (pins_raw),
    .sync_o (pins_sync)
  );

  // Word bit order kept as on the pins, bit nine most significant
  assign {s_word, s_pclk, s_edge_sel, s_dir, s_addr,
          s_start_cs, s_xfr, s_pol, s_standby_request} = pins_sync; // see [R1]

  // Pixel clock edge detection
  logic pclk_prev;
  logic next_pclk_prev;
  logic pclk_rise;
  logic pclk_fall;
  logic capture;

  assign pclk_rise = s_pclk && !pclk_prev;
  assign pclk_fall = !s_pclk && pclk_prev;
  // Data is taken from the same sample that shows the edge; hold time covers it
  assign capture   = !s_standby_request && (s_edge_sel ? pclk_rise : pclk_fall); // see [R3]

  always_comb begin
    next_pclk_prev = pclk_prev;
    if (ce_i) begin
      next_pclk_prev = s_pclk;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclk_prev <= 1'b0;
    end else begin
      pclk_prev <= next_pclk_prev;
    end
  end

  // Channel selection
  loader_pkg::seq_state_e seq_state;
  loader_pkg::seq_state_e next_seq_state;
  logic [2:0]             seq_ch;
  logic [2:0]             next_seq_ch;
  logic                   load_en;
  logic [2:0]             load_ch;
  logic [2:0]             first_ch;
  logic [2:0]             last_ch;
  logic                   seq_mode;

  assign seq_mode = (s_addr == loader_pkg::ADDR_SEQ); // see [R5]
  assign first_ch = s_dir ? loader_pkg::ADDR_LAST_CH
                          : loader_pkg::ADDR_FIRST_CH; // see [R10]
  assign last_ch  = s_dir ? loader_pkg::ADDR_FIRST_CH
                          : loader_pkg::ADDR_LAST_CH;

  always_comb begin
    next_seq_state = seq_state;
    next_seq_ch    = seq_ch;
    load_en        = 1'b0;
    load_ch        = seq_ch;
    if (ce_i && s_standby_request) begin
      next_seq_state = loader_pkg::SEQ_IDLE; // see [R13]
      next_seq_ch    = loader_pkg::ADDR_FIRST_CH;
    end else if (ce_i && capture) begin
      if (!seq_mode) begin
        next_seq_state = loader_pkg::SEQ_IDLE;
        // Address 6 has no channel and is ignored
        if (s_start_cs && s_addr <= loader_pkg::ADDR_LAST_CH) begin // see [R17]
          load_en = 1'b1; // see [R6]
          load_ch = s_addr; // see [R7]
        end
      end else if (s_start_cs) begin
        // A start pulse loads this word into the first channel; restarts a run
        load_en = 1'b1; // see [R8]
        load_ch = first_ch; // see [R14]
        next_seq_state = loader_pkg::SEQ_RUN;
        next_seq_ch    = s_dir ? first_ch - 3'h1 : first_ch + 3'h1; // see [R9]
      end else begin
        case (seq_state)
          loader_pkg::SEQ_IDLE: begin
            next_seq_state = loader_pkg::SEQ_IDLE;
          end
          loader_pkg::SEQ_RUN: begin
            load_en = 1'b1;
            load_ch = seq_ch;
            if (seq_ch == last_ch) begin
              next_seq_state = loader_pkg::SEQ_IDLE;
            end else begin
              next_seq_ch = s_dir ? seq_ch - 3'h1 : seq_ch + 3'h1; // see [R15]
            end
          end
          default: begin
            next_seq_state = loader_pkg::SEQ_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_state <= loader_pkg::SEQ_IDLE;
      seq_ch    <= loader_pkg::ADDR_FIRST_CH;
    end else begin
      seq_state <= next_seq_state;
      seq_ch    <= next_seq_ch;
    end
  end

  assign sequence_busy_o = (seq_state == loader_pkg::SEQ_RUN);

  // Channel holding latches
  logic [DATA_W-1:0] hold      [NUM_CH];
  logic [DATA_W-1:0] next_hold [NUM_CH];

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_hold[i] = hold[i];
      if (load_en && load_ch == 3'(i)) begin
        next_hold[i] = s_word; // see [R2]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        hold[i] <= loader_pkg::WORD_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        hold[i] <= next_hold[i];
      end
    end
  end

  // Transfer: armed at rising pixel edge, fired at the next falling edge
  logic xfr_armed;
  logic next_xfr_armed;
  logic xfr_fire;
  logic lost;
  logic next_lost;
  logic frame_ready;
  logic [FRAME_W-1:0] frame_in;
  logic [FRAME_W-1:0] frame_out;

  assign xfr_fire = ce_i && xfr_armed && pclk_fall && !s_standby_request; // see [R11]

  always_comb begin
    next_xfr_armed = xfr_armed;
    next_lost      = 1'b0;
    if (ce_i) begin
      if (s_standby_request) begin
        next_xfr_armed = 1'b0;
      end else if (pclk_rise) begin
        next_xfr_armed = s_xfr;
      end else if (pclk_fall) begin
        next_xfr_armed = 1'b0;
      end
      // A full buffer cannot take the frame; flag it rather than stall pins
      next_lost = xfr_fire && !frame_ready;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfr_armed <= 1'b0;
      lost      <= 1'b0;
    end else begin
      xfr_armed <= next_xfr_armed;
      lost      <= next_lost;
    end
  end

  // All six words travel as one frame, polarity with them
  always_comb begin
    frame_in = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      frame_in[i*DATA_W +: DATA_W] = hold[i]; // see [R16]
    end
    frame_in[FRAME_W-1] = s_pol; // see [R12]
  end

  two_entry_buffer #(
    .W     (FRAME_W),
    .DEPTH (loader_pkg::BUF_DEPTH)
  ) u_frame_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (xfr_fire),
    .in_ready_o  (frame_ready),
    .in_data_i   (frame_in),
    .out_valid_o (column_valid_o),
    .out_ready_i (column_ready_i),
    .out_data_o  (frame_out)
  );

  assign column_outputs_o   = frame_out[NUM_CH*DATA_W-1:0];
  assign column_above_mid_o = frame_out[FRAME_W-1];
  assign transfer_ready_o   = frame_ready;
  assign transfer_lost_o    = lost;

  // Word spacing monitor for the upstream rate limit
  logic [GAP_W-1:0] gap;
  logic [GAP_W-1:0] next_gap;
  logic             rate_bad;
  logic             next_rate_bad;

  always_comb begin
    next_gap      = gap;
    next_rate_bad = 1'b0;
    if (ce_i) begin
      if (capture) begin
        next_rate_bad = (gap < GAP_W'(loader_pkg::MIN_WORD_CYCLES)); // see [R4]
        next_gap      = GAP_W'(1);
      end else if (gap != GAP_W'(loader_pkg::MIN_WORD_CYCLES)) begin
        next_gap = gap + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap      <= GAP_W'(loader_pkg::MIN_WORD_CYCLES);
      rate_bad <= 1'b0;
    end else begin
      gap      <= next_gap;
      rate_bad <= next_rate_bad;
    end
  end

  assign rate_violation_o = rate_bad;

  // Standby status, also used downstream to debias the converters
  logic standby_request_q;
  logic next_standby_request_q;

  always_comb begin
    next_standby_request_q = standby_request_q;
    if (ce_i) begin
      next_standby_request_q = s_standby_request; // see [R13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_request_q <= 1'b0;
    end else begin
      standby_request_q <= next_standby_request_q;
    end
  end

  assign standby_o = standby_request_q;

endmodule : six_channel_decimating_input_loader

/* sim/pixel_controller.sv */
`timescale 1ns/1ps
module pixel_controller (
  // Core clock
  input  wire logic clk_i,
  // Panel pins
  output logic       pclk_o,
  output logic [9:0] word_o,
  output logic [2:0] addr_o,
  output logic       sel_o,
  output logic       xfr_o
);
  // Set by the bench when words are captured on the rising edge
  logic rise = 1'b0;

  initial begin
    pclk_o = 1'b0;
    word_o = 10'h000;
    addr_o = 3'h6;
    sel_o  = 1'b0;
    xfr_o  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Released lines show the inverse, not a kind stale value
  task automatic drop(input logic [9:0] w);
    word_o = ~w;
    sel_o  = 1'b0;
    xfr_o  = 1'b0;
  endtask : drop

  // Breaks the word rate on purpose; address 6 so no latch is touched
  task automatic burst(input int n);
    addr_o = 3'h6;
    sel_o  = 1'b0;
    repeat (n) begin
      pclk_o = 1'b1;
      tick(1);
      pclk_o = 1'b0;
      tick(1);
    end
  endtask : burst

  // Four core cycles high and six low keep words under 75 million per second
  task automatic send(input logic [2:0] a, input logic s, input logic [9:0] w,
                      input logic x);
    word_o = w;
    addr_o = a;
    sel_o  = s;
    xfr_o  = x;
    tick(2);
    pclk_o = 1'b1;
    tick(2);
    if (rise) drop(w);
    tick(2);
    pclk_o = 1'b0;
    tick(2);
    if (!rise) drop(w);
    tick(2);
  endtask : send
endmodule : pixel_controller

/* sim/loader_assertions.sv */
`timescale 1ns/1ps
module loader_assertions #(
  parameter int unsigned DATA_W = 10,
  parameter int unsigned NUM_CH = 6
) (
  // Clock and reset
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  // Panel-side pins
  input wire logic                     pixel_clk_i,
  input wire logic                     seq_start_or_select_i,
  input wire logic                     standby_request_i,
  // Converter side
  input wire logic [NUM_CH*DATA_W-1:0] column_outputs_o,
  input wire logic                     column_above_mid_o,
  input wire logic                     column_valid_o,
  input wire logic                     column_ready_i,
  // Status
  input wire logic                     transfer_ready_o,
  input wire logic                     transfer_lost_o,
  input wire logic                     sequence_busy_o,
  input wire logic                     standby_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_head_holds: assert property (
    column_valid_o && !column_ready_i |=> column_valid_o && $stable(column_outputs_o)
    && $stable(column_above_mid_o)) else $error("head frame moved while stalled");
  chk_lost_full: assert property (
    transfer_lost_o |-> !$past(transfer_ready_o)) else $error("loss without full buffer");
  chk_lost_pulse: assert property (
    transfer_lost_o |=> !transfer_lost_o) else $error("loss pulse too long");
  chk_full_valid: assert property (
    !transfer_ready_o |-> column_valid_o) else $error("full buffer without valid head");
  chk_standby_seen: assert property (
    $rose(standby_request_i) |-> ##[1:4] standby_o) else $error("standby not entered");
  chk_standby_idle: assert property (
    standby_o ##1 standby_o |-> !sequence_busy_o) else $error("sequencer runs in standby");
  chk_busy_cause: assert property (
    $rose(sequence_busy_o) |-> $past(seq_start_or_select_i, 2)
    || $past(seq_start_or_select_i, 3) || $past(seq_start_or_select_i, 4))
    else $error("sequence started without start pulse");
  chk_valid_fall: assert property (
    $rose(column_valid_o) |-> !$past(pixel_clk_i, 2)) else $error("push not after falling edge");
endmodule : loader_assertions

bind six_channel_decimating_input_loader loader_assertions #(
  .DATA_W(DATA_W), .NUM_CH(NUM_CH)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .pixel_clk_i(pixel_clk_i),
  .seq_start_or_select_i(seq_start_or_select_i), .standby_request_i(standby_request_i),
  .column_outputs_o(column_outputs_o), .column_above_mid_o(column_above_mid_o),
  .column_valid_o(column_valid_o), .column_ready_i(column_ready_i),
  .transfer_ready_o(transfer_ready_o), .transfer_lost_o(transfer_lost_o),
  .sequence_busy_o(sequence_busy_o), .standby_o(standby_o));

/* sim/six_channel_decimating_input_loader_tb.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module six_channel_decimating_input_loader_tb;
  // Bench controls
  logic        clk_i;
  logic        rst_i;
  logic        edge_sel;
  logic        dir;
  logic        pol;
  logic        standby_request;
  logic        col_ready;
  logic        ce;
  logic        lost_seen;
  logic        rate_seen;
  int          mismatches;
  int          cmp_count;
  logic [9:0]  w;
  logic [59:0] exp_f;
  // Panel pins and design outputs
  logic        pclk;
  logic [9:0]  word;
  logic [2:0]  addr;
  logic        sel;
  logic        converter_transfer_strobe;
  logic [59:0] cols;
  logic        above;
  logic        valid;
  logic        tready;
  logic        lost;
  logic        busy;
  logic        standby_request_o;
  logic        rate;

  pixel_controller ctl (.clk_i(clk_i), .pclk_o(pclk), .word_o(word), .addr_o(addr),
                        .sel_o(sel), .xfr_o(converter_transfer_strobe));
  six_channel_decimating_input_loader DUT (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .pixel_clk_i(pclk),
    .pixel_word_in_i(word), .capture_edge_select_i(edge_sel),
    .sequence_direction_i(dir), .channel_address_i(addr),
    .seq_start_or_select_i(sel), .converter_transfer_strobe_i(converter_transfer_strobe),
    .output_polarity_select_i(pol), .standby_request_i(standby_request),
    .column_outputs_o(cols), .column_above_mid_o(above), .column_valid_o(valid),
    .column_ready_i(col_ready), .transfer_ready_o(tready), .transfer_lost_o(lost),
    .rate_violation_o(rate), .sequence_busy_o(busy), .standby_o(standby_request_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Loss and rate flags are one-cycle pulses, so keep them sticky
  always @(posedge clk_i) if (lost === 1'b1) lost_seen <= 1'b1;
  always @(posedge clk_i) if (rate === 1'b1) rate_seen <= 1'b1;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // Strobe cycle aimed at channel 0 without select
  task automatic xfer(input logic p);
    pol = p;
    ctl.send(3'h0, 1'b0, 10'h3FF, 1'b1);
  endtask : xfer

  task automatic get_frame(input logic p);
    for (int i = 0; i < 40 && valid !== 1'b1; i++) ctl.tick(1);
    `CHECK(valid, 1'b1)
    `CHECK(cols, exp_f)
    `CHECK(above, p)
    col_ready = 1'b1;
    ctl.tick(1);
    col_ready = 1'b0;
  endtask : get_frame

  task automatic t_addressed();
    for (int a = 0; a < 6; a++) begin
      w = 10'h2A5 ^ 10'(a * 67);
      exp_f[10*a +: 10] = w;
      ctl.send(3'(a), 1'b1, w, 1'b0);
    end
    ctl.send(3'h6, 1'b1, 10'h155, 1'b0);
    ctl.send(3'h2, 1'b0, 10'h2AA, 1'b0);
    xfer(1'b1);
    get_frame(1'b1);
  endtask : t_addressed

  task automatic t_sequence(input logic d);
    dir = d;
    for (int i = 0; i < 6; i++) begin
      w = 10'h1C3 ^ 10'(i * 91) ^ {10{d}};
      exp_f[10*(d ? 5 - i : i) +: 10] = w;
      ctl.send(3'h7, i == 0, w, 1'b0);
      if (i == 2) `CHECK(busy, 1'b1)
    end
    ctl.tick(3);
    `CHECK(busy, 1'b0)
    xfer(1'b0);
    get_frame(1'b0);
  endtask : t_sequence

  // Word changes after the rising edge, so a falling capture would miss it
  task automatic t_rising();
    edge_sel = 1'b1;
    ctl.rise = 1'b1;
    exp_f[39:30] = 10'h0F0;
    ctl.send(3'h3, 1'b1, 10'h0F0, 1'b0);
    xfer(1'b1);
    get_frame(1'b1);
    edge_sel = 1'b0;
    ctl.rise = 1'b0;
  endtask : t_rising

  task automatic t_stall();
    lost_seen = 1'b0;
    xfer(1'b0);
    xfer(1'b1);
    `CHECK(tready, 1'b0)
    `CHECK(lost_seen, 1'b0)
    xfer(1'b0);
    `CHECK(lost_seen, 1'b1)
    get_frame(1'b0);
    get_frame(1'b1);
    ctl.tick(2);
    `CHECK(valid, 1'b0)
    `CHECK(tready, 1'b1)
  endtask : t_stall

  task automatic t_standby();
    standby_request = 1'b1;
    ctl.tick(4);
    `CHECK(standby_request_o, 1'b1)
    ctl.send(3'h1, 1'b1, 10'h111, 1'b0);
    xfer(1'b1);
    `CHECK(valid, 1'b0)
    standby_request = 1'b0;
    ctl.tick(4);
    `CHECK(standby_request_o, 1'b0)
    xfer(1'b1);
    get_frame(1'b1);
  endtask : t_standby

  // Enable low must hold the head frame even with the receiver ready
  task automatic t_freeze();
    xfer(1'b0);
    ce = 1'b0;
    col_ready = 1'b1;
    ctl.tick(4);
    `CHECK(valid, 1'b1)
    col_ready = 1'b0;
    ce = 1'b1;
    get_frame(1'b0);
    `CHECK(valid, 1'b0)
  endtask : t_freeze

  // Earlier scenarios kept the rate, so no flag until the burst
  task automatic t_rate();
    `CHECK(rate_seen, 1'b0)
    ctl.burst(4);
    ctl.tick(4);
    `CHECK(rate_seen, 1'b1)
  endtask : t_rate

  initial begin
    rst_i = 1'b1;
    edge_sel = 1'b0;
    dir = 1'b0;
    pol = 1'b0;
    standby_request = 1'b0;
    col_ready = 1'b0;
    ce = 1'b1;
    lost_seen = 1'b0;
    rate_seen = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_addressed();
    t_sequence(1'b0);
    t_sequence(1'b1);
    t_rising();
    t_stall();
    t_standby();
    t_freeze();
    t_rate();
    close_out();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    close_out();
  end
endmodule : six_channel_decimating_input_loader_tb
